/* bench/etcs_master.sv */
// two-wire bus master model: scl and an open-drain pull on sda
// assumes: the bench resolves sda with a pull-up from all pulls
`timescale 1ns/1ns
module etcs_master #(
  parameter int HP = 40 // half period, scaled down like the tick
) (
  // bus pins
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // scl stands high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // data moves 10 ns after scl falls so no false start or stop is seen;
  // pins change by nonblocking update so a clock edge never races them
  task automatic bit_x(input logic b, output logic r);
    #10 sda_low <= ~b;
    #(HP - 10) scl <= 1'b1;
    r = sda;
    #HP scl <= 1'b0;
  endtask : bit_x
  task automatic start;
    #10 sda_low <= 1'b0;
    #(HP - 10) scl <= 1'b1;
    #HP sda_low <= 1'b1;
    #HP scl <= 1'b0;
  endtask : start
  task automatic stop;
    #10 sda_low <= 1'b1;
    #(HP - 10) scl <= 1'b1;
    #HP sda_low <= 1'b0;
    #HP;
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(~ack, r);
  endtask : rbyte
endmodule : etcs_master

/* bench/etcs_top_tb.sv */
// bench of the control core: register traffic over the two-wire link
// assumes: etcs_master model; pull-ups on sda and the alarm pin
`timescale 1ns/1ns
module etcs_top_tb;
  import etcs_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic event_in = 1'b0;
  logic ext_low = 1'b0;
  logic a;
  wire scl;
  wire m_low;
  wire sda_oe;
  wire sda_out;
  wire alarm_oe;
  wire alarm_out;
  wire sda = ~(sda_oe | m_low);
  wire alarm_pin = ~(alarm_oe | ext_low);
  int bad_count = 0;
  int num_checks = 0;
  int pulses = 0;
  initial forever #4 clock = ~clock;
  always @(posedge alarm_oe) pulses++;
  etcs_top #(.QTR_CYC(4), .LOW_CYC(3), .HIGH_CYC(5)) u_etcs_top (
    .clock(clock), .resetn(resetn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .event_in(event_in),
    .alarm_in(alarm_pin), .alarm_out(alarm_out), .alarm_oe(alarm_oe));
  etcs_master u_etcs_master (.scl(scl), .sda_low(m_low), .sda(sda));
  task automatic chk(input string n, input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic wb(input etcs_byte_t d);
    logic k;
    u_etcs_master.wbyte(d, k);
    chk("ack", {15'h0000, k}, 16'h0001);
  endtask : wb
  task automatic go(input etcs_byte_t p);
    u_etcs_master.start();
    wb(8'hd6);
    wb(p);
  endtask : go
  task automatic w1(input etcs_byte_t p, input etcs_byte_t d);
    go(p);
    wb(d);
    u_etcs_master.stop();
  endtask : w1
  task automatic w2(input etcs_byte_t p, input logic [15:0] d);
    go(p);
    wb(d[7:0]);
    wb(d[15:8]);
    u_etcs_master.stop();
  endtask : w2
  // two bytes read lsb first, last one not acknowledged
  task automatic rc(input string n, input etcs_byte_t p, input logic [15:0] e);
    logic [15:0] v;
    go(p);
    u_etcs_master.start();
    wb(8'hd7);
    u_etcs_master.rbyte(1'b1, v[7:0]);
    u_etcs_master.rbyte(1'b0, v[15:8]);
    u_etcs_master.stop();
    chk(n, v, e);
  endtask : rc
  task automatic ev(input int n);
    @(posedge clock) event_in <= 1'b1;
    repeat (n) @(posedge clock);
    event_in <= 1'b0;
    repeat (20) @(posedge clock);
  endtask : ev
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    rc("ctrl", 8'h00, 16'h0000);
    rc("cfg cmd", 8'h1e, 16'h0000);
    u_etcs_master.start();
    u_etcs_master.wbyte(8'hd4, a);
    u_etcs_master.stop();
    chk("other addr", {15'h0000, a}, 16'h0000);
    w1(8'h01, 8'h02);
    w1(8'h00, 8'hf6);
    rc("ctrl thr", 8'h00, 16'h0286);
    w2(8'h0b, 16'hb2a1);
    rc("user mem", 8'h0b, 16'hb2a1);
    // bus stays silent while the event input is high
    @(posedge clock) event_in <= 1'b1;
    repeat (30) @(posedge clock);
    u_etcs_master.start();
    u_etcs_master.wbyte(8'hd6, a);
    u_etcs_master.stop();
    @(negedge clock);
    chk("busy ack", {15'h0000, a}, 16'h0000);
    chk("alarm pin", {15'h0000, alarm_oe}, 16'h0001);
    @(posedge clock) event_in <= 1'b0;
    repeat (20) @(posedge clock);
    rc("ctrl flag", 8'h00, 16'h02c6);
    rc("events", 8'h09, 16'h0001);
    w1(8'h00, 8'h84);
    repeat (5) @(posedge clock);
    @(negedge clock);
    chk("alarm off", {15'h0000, alarm_oe}, 16'h0000);
    rc("flag off", 8'h00, 16'h0284);
    // style 1: onset, then an outside pull and release
    pulses = 0;
    w1(8'h00, 8'h8e);
    repeat (80) @(posedge clock);
    chk("onset pulses", pulses[15:0], 16'h0004);
    pulses = 0;
    @(posedge clock) ext_low <= 1'b1;
    repeat (20) @(posedge clock);
    ext_low <= 1'b0;
    repeat (80) @(posedge clock);
    chk("pull pulses", pulses[15:0], 16'h0004);
    w1(8'h00, 8'h84);
    w2(8'h09, 16'hffff);
    ev(10);
    rc("wrap", 8'h09, 16'h0000);
    rc("ovf", 8'h00, 16'h0285);
    w2(8'h09, 16'hffff);
    ev(10);
    rc("stick", 8'h09, 16'hffff);
    w1(8'h00, 8'h80);
    w1(8'h1d, 8'h55);
    rc("no clear", 8'h09, 16'hffff);
    w1(8'h00, 8'h84);
    w1(8'h1d, 8'h55);
    rc("clr ev", 8'h09, 16'h0000);
    rc("clr ctrl", 8'h00, 16'h0000);
    rc("clr mem", 8'h0b, 16'h0000);
    rc("clr ela", 8'h05, 16'h0000);
    w1(8'h0b, 8'h33);
    w1(8'h1f, 8'haa);
    w1(8'h1f, 8'haa);
    w1(8'h0b, 8'h77);
    w1(8'h01, 8'h05);
    rc("mem lock", 8'h0b, 16'h0033);
    rc("thr open", 8'h00, 16'h05d0);
    rc("mem cmd", 8'h1f, 16'h0000);
    w1(8'h1e, 8'haa);
    w1(8'h1e, 8'haa);
    w1(8'h01, 8'h09);
    w1(8'h00, 8'h04);
    w2(8'h09, 16'h1234);
    rc("cfg lock", 8'h00, 16'h05f0);
    rc("ev frozen", 8'h09, 16'h0000);
    @(negedge clock);
    chk("pad levels", {14'h0000, sda_out, alarm_out}, 16'h0000);
    conclude();
  end
  // the whole sequence needs about 145 us
  initial begin
    #400_000;
    bad_count++;
    conclude();
  end
endmodule : etcs_top_tb

/* logic/etcs_alarm_pulse.sv */
// alarm pin shaper: steady low or a train of four low pulses
// assumes: pin_low is already synchronised; drive means pull pin low
`timescale 1ns/1ns
`include "etcs_map.svh"
module etcs_alarm_pulse #(
  parameter int unsigned LOW_CYC = `ETCS_PLOW_US * `ETCS_CLK_MHZ,
  parameter int unsigned HIGH_CYC = `ETCS_PHIGH_US * `ETCS_CLK_MHZ
) (
  // system
  input wire logic clock,
  input wire logic resetn,
  // alarm request and pin
  etcs_alm_if.sink al
);
  import etcs_pkg::*;
  logic boot_q, act_p_q, run_q, low_ph_q, drive_q, ext_q;
  logic [1:0] npul_q;
  logic [31:0] tm_q;
  logic trig;
  // external pull-low only counts while idle, so our own pulses never
  // retrigger the train through the pin's synchroniser lag
  assign trig = boot_q | (al.active & ~act_p_q) |
                (ext_q & ~al.pin_low);
  always_ff @(posedge clock) begin
    if (!resetn) begin
      boot_q <= 1'b1;
      act_p_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      boot_q <= 1'b0;
      act_p_q <= al.active;
      ext_q <= al.pin_low & ~run_q & ~drive_q & al.style;
    end
  end
  always_ff @(posedge clock) begin
    if (!resetn) begin
      run_q <= 1'b0;
      low_ph_q <= 1'b0;
      npul_q <= 2'h0;
      tm_q <= 32'h0000_0000;
    end else if (!run_q) begin
      if (trig && al.style) begin
        run_q <= 1'b1;
        low_ph_q <= 1'b1;
        npul_q <= 2'h0;
        tm_q <= 32'h0000_0000;
      end
    end else if (low_ph_q) begin
      tm_q <= tm_q + 32'h0000_0001;
      if (tm_q == 32'(LOW_CYC - 1)) begin
        low_ph_q <= 1'b0;
        tm_q <= 32'h0000_0000;
      end
    end else begin
      tm_q <= tm_q + 32'h0000_0001;
      if (tm_q == 32'(HIGH_CYC - 1)) begin
        tm_q <= 32'h0000_0000;
        if (npul_q == `ETCS_LAST_PULSE) begin
          run_q <= 1'b0;
        end else begin
          npul_q <= npul_q + 2'h1;
          low_ph_q <= 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!resetn) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= al.style ? (run_q & low_ph_q) : al.active;
    end
  end
  assign al.drive = drive_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence style_trig_s;
    al.style && !run_q && trig;
  endsequence
  steady_low_a: assert property (
    !al.style && al.active ##1 !al.style |-> drive_q)
    else $error("steady alarm not driven");
  train_start_a: assert property (
    style_trig_s ##1 al.style |=> drive_q ##1 run_q)
    else $error("pulse train did not start");
endmodule : etcs_alarm_pulse

/* logic/etcs_alm_if.sv */
// alarm request and pin drive between the core and the pulse shaper
// assumes: both ends run on the same clock
`timescale 1ns/1ns
interface etcs_alm_if;
  logic active;
  logic style;
  logic pin_low;
  logic drive;
  modport src (output active, output style, output pin_low, input drive);
  modport sink (input active, input style, input pin_low, output drive);
endinterface : etcs_alm_if

/* logic/etcs_map.svh */
// constants of the elapsed time control and serial slave block
// assumes: included by bare name from the two design files; the package does not include it
`ifndef ETCS_MAP_SVH
`define ETCS_MAP_SVH
// system clock and timing figures
`define ETCS_CLK_MHZ 125
`define ETCS_TICK_US 250_000
`define ETCS_PLOW_US 62_500
`define ETCS_PHIGH_US 437_500
// slave address: device type and select bits
`define ETCS_DEV_TYPE 4'hd
`define ETCS_DEV_SEL 3'h3
// register pointer map, multi-byte fields are lsb first
`define ETCS_A_CTRL 8'h00
`define ETCS_A_THR 8'h01
`define ETCS_A_ELA 8'h05
`define ETCS_A_EVT 8'h09
`define ETCS_A_UMEM 8'h0b
`define ETCS_A_UEND 8'h15
`define ETCS_A_CLR 8'h1d
`define ETCS_A_CFGL 8'h1e
`define ETCS_A_MEML 8'h1f
`define ETCS_UMEM_N 10
// command keys
`define ETCS_LOCK_KEY 8'haa
`define ETCS_CLR_KEY 8'h55
// control register field positions
`define ETCS_B_STYLE 3
`define ETCS_B_PERMIT 2
`define ETCS_B_SENSE 1
// counts
`define ETCS_BYTE_BITS 4'h8
`define ETCS_LAST_BIT 4'h7
`define ETCS_CNT_MAX 16'hffff
`define ETCS_ELA_MAX 32'hffff_ffff
`define ETCS_LAST_PULSE 2'h3
`endif

/* logic/etcs_pkg.sv */
// types of the elapsed time control and serial slave block
// assumes: nothing beyond the map header
package etcs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_ACK = 3'h2,
    ST_TX = 3'h3,
    ST_TXACK = 3'h4
  } etcs_state_t;
  typedef logic [7:0] etcs_byte_t;
endpackage : etcs_pkg

/* logic/etcs_top.sv */
// elapsed time control, protection and two-wire slave core
// assumes: scl, sda, event and alarm pins are asynchronous to clock;
// the pad resolves each open-drain pin from its output enable
//
// Behaviour
// - armed bit follows non-zero threshold; host writes and clear ignore it
// - alarm flag mirrors active alarm; clear drops it; next event sets it
// - two lock commands set config lock; threshold and control freeze
// - config lock with clear permit 0 blocks host writes and clear of total, elapsed, events; they still count
// - two memory lock commands freeze the ten user bytes forever
// - style 0: alarm pin steady low while alarm is active
// - style 1: four low pulses at pin release and alarm onset; none at boot, since style resets to 0
// - clear command honoured only while clear permit is set
// - unlocked clear zeroes counters, threshold, control and user memory
// - sense 1: active when time >= threshold; sense 0: when below
// - overflow is control register bit 0; wraps once, then counter sticks
// - lock command registers always read zero
// - memory lock leaves other registers and clear untouched
// - under config lock only clear, memory lock commands, unlocked user memory and, with clear permit set, elapsed and events write
// - receiver holds sda low through each ninth acknowledge clock
// - master nacks last read byte; device releases sda
// - start and stop found from sda edges while scl high
// - sda changes only while scl is low, except the release when the event input goes high
// - any number of bytes per transfer
// - address matched in hardware; write receives, read transmits
// - address is type 1101, select 011, then direction bit
// - no bus response while event input is high
`timescale 1ns/1ns
`include "etcs_map.svh"
module etcs_top #(
  parameter int unsigned QTR_CYC = `ETCS_TICK_US * `ETCS_CLK_MHZ,
  parameter int unsigned LOW_CYC = `ETCS_PLOW_US * `ETCS_CLK_MHZ,
  parameter int unsigned HIGH_CYC = `ETCS_PHIGH_US * `ETCS_CLK_MHZ
) (
  // system
  input wire logic clock,
  input wire logic resetn,
  // two-wire link
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // event and alarm pins
  input wire logic event_in,
  input wire logic alarm_in,
  output logic alarm_out,
  output logic alarm_oe
);
  import etcs_pkg::*;
  localparam logic [3:0] SYNC_IDLE = 4'hb;
  logic [3:0] raw, s1_q, s2_q;
  logic scl, sda, evt, apin, scl_p_q, sda_p_q, evt_p_q;
  logic scl_r, scl_f, start, stop, evt_r, evt_f;
  assign raw = {alarm_in, event_in, sda_in, scl_in};
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge clock) begin
      if (!resetn) begin
        s1_q[i] <= SYNC_IDLE[i];
        s2_q[i] <= SYNC_IDLE[i];
      end else begin
        s1_q[i] <= raw[i];
        s2_q[i] <= s1_q[i];
      end
    end
  end
  assign {apin, evt, sda, scl} = s2_q;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      evt_p_q <= 1'b0;
    end else begin
      scl_p_q <= scl;
      sda_p_q <= sda;
      evt_p_q <= evt;
    end
  end
  assign scl_r = scl & ~scl_p_q;
  assign scl_f = ~scl & scl_p_q;
  assign start = scl & scl_p_q & sda_p_q & ~sda;
  assign stop = scl & scl_p_q & ~sda_p_q & sda;
  assign evt_r = evt & ~evt_p_q;
  assign evt_f = ~evt & evt_p_q;

  // register state
  logic style_q, permit_q, sense_q, armed_q, flag_q, ovf_q;
  logic cfg_lock_q, mem_lock_q, cfg_hit_q, mem_hit_q, act_q, act_p_q;
  logic [31:0] thr_q, ela_q, tts_q, tdiv_q;
  logic [15:0] evt_cnt_q;
  logic [`ETCS_UMEM_N-1:0][7:0] umem_q;
  // link state
  etcs_state_t state_q;
  logic [3:0] bit_q;
  etcs_byte_t sh_q, ptr_q, rd, ctl;
  logic [1:0] nb_q;
  logic rw_q, oe_q, nack_q, ld_q, zero_q;
  logic wr_en, ld_go, do_clr, cnt_open, tick;
  logic in_thr, in_ela, in_evt, in_um;
  etcs_byte_t o_thr, o_ela, o_evt, o_um;

  assign in_thr = ptr_q >= `ETCS_A_THR && ptr_q < `ETCS_A_ELA;
  assign in_ela = ptr_q >= `ETCS_A_ELA && ptr_q < `ETCS_A_EVT;
  assign in_evt = ptr_q >= `ETCS_A_EVT && ptr_q < `ETCS_A_UMEM;
  assign in_um = ptr_q >= `ETCS_A_UMEM && ptr_q < `ETCS_A_UEND;
  assign o_thr = ptr_q - `ETCS_A_THR;
  assign o_ela = ptr_q - `ETCS_A_ELA;
  assign o_evt = ptr_q - `ETCS_A_EVT;
  assign o_um = ptr_q - `ETCS_A_UMEM;
  assign ctl = {armed_q, flag_q, cfg_lock_q, mem_lock_q,
                style_q, permit_q, sense_q, ovf_q};

  always_comb begin
    rd = 8'h00;
    if (ptr_q == `ETCS_A_CTRL) begin
      rd = ctl;
    end else if (in_thr) begin
      rd = thr_q[{o_thr[1:0], 3'h0} +: 8];
    end else if (in_ela) begin
      rd = ela_q[{o_ela[1:0], 3'h0} +: 8];
    end else if (in_evt) begin
      rd = evt_cnt_q[{o_evt[0], 3'h0} +: 8];
    end else if (in_um) begin
      rd = umem_q[o_um[3:0]];
    end
  end

  // a data byte lands on the falling edge that closes its eighth bit
  assign wr_en = state_q == ST_RX && scl_f && bit_q == `ETCS_BYTE_BITS &&
                 nb_q == 2'h2 && !rw_q;
  assign do_clr = wr_en && ptr_q == `ETCS_A_CLR &&
                  sh_q == `ETCS_CLR_KEY && permit_q;
  assign ld_go = scl_f && ((state_q == ST_ACK && rw_q) ||
                           (state_q == ST_TXACK && !nack_q));

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      nb_q <= 2'h0;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
      nack_q <= 1'b0;
      ld_q <= 1'b0;
    end else begin
      ld_q <= 1'b0;
      if (evt) begin
        state_q <= ST_IDLE;
        oe_q <= 1'b0;
      end else if (start) begin
        state_q <= ST_RX;
        bit_q <= 4'h0;
        nb_q <= 2'h0;
        oe_q <= 1'b0;
      end else if (stop) begin
        state_q <= ST_IDLE;
        oe_q <= 1'b0;
      end else if (ld_go) begin
        sh_q <= rd;
        ptr_q <= ptr_q + 8'h01;
        oe_q <= ~rd[7];
        bit_q <= 4'h0;
        ld_q <= 1'b1;
        state_q <= ST_TX;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            oe_q <= 1'b0;
          end
          ST_RX: begin
            if (scl_r) begin
              sh_q <= {sh_q[6:0], sda};
              bit_q <= bit_q + 4'h1;
            end else if (scl_f && bit_q == `ETCS_BYTE_BITS) begin
              bit_q <= 4'h0;
              if (nb_q == 2'h0) begin
                if (sh_q[7:1] == {`ETCS_DEV_TYPE, `ETCS_DEV_SEL}) begin
                  rw_q <= sh_q[0];
                  oe_q <= 1'b1;
                  nb_q <= 2'h1;
                  state_q <= ST_ACK;
                end else begin
                  state_q <= ST_IDLE;
                end
              end else begin
                oe_q <= 1'b1;
                nb_q <= 2'h2;
                state_q <= ST_ACK;
                if (nb_q == 2'h1) begin
                  ptr_q <= sh_q;
                end else begin
                  ptr_q <= ptr_q + 8'h01;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_f) begin
              oe_q <= 1'b0;
              state_q <= ST_RX;
            end
          end
          ST_TX: begin
            if (scl_f) begin
              if (bit_q == `ETCS_LAST_BIT) begin
                oe_q <= 1'b0;
                state_q <= ST_TXACK;
              end else begin
                sh_q <= {sh_q[6:0], 1'b0};
                oe_q <= ~sh_q[6];
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          ST_TXACK: begin
            if (scl_r) begin
              nack_q <= sda;
            end else if (scl_f) begin
              state_q <= ST_IDLE;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // permanent locks need two back-to-back key writes to the same register
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cfg_hit_q <= 1'b0;
      mem_hit_q <= 1'b0;
      cfg_lock_q <= 1'b0;
      mem_lock_q <= 1'b0;
    end else if (wr_en) begin
      cfg_hit_q <= ptr_q == `ETCS_A_CFGL && sh_q == `ETCS_LOCK_KEY;
      mem_hit_q <= ptr_q == `ETCS_A_MEML && sh_q == `ETCS_LOCK_KEY;
      if (cfg_hit_q && ptr_q == `ETCS_A_CFGL &&
          sh_q == `ETCS_LOCK_KEY) begin
        cfg_lock_q <= 1'b1;
      end
      if (mem_hit_q && ptr_q == `ETCS_A_MEML &&
          sh_q == `ETCS_LOCK_KEY) begin
        mem_lock_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      style_q <= 1'b0;
      permit_q <= 1'b0;
      sense_q <= 1'b0;
      thr_q <= 32'h0000_0000;
    end else if (do_clr && !cfg_lock_q) begin
      style_q <= 1'b0;
      permit_q <= 1'b0;
      sense_q <= 1'b0;
      thr_q <= 32'h0000_0000;
    end else if (wr_en && !cfg_lock_q) begin
      if (ptr_q == `ETCS_A_CTRL) begin
        style_q <= sh_q[`ETCS_B_STYLE];
        permit_q <= sh_q[`ETCS_B_PERMIT];
        sense_q <= sh_q[`ETCS_B_SENSE];
      end
      if (in_thr) begin
        thr_q[{o_thr[1:0], 3'h0} +: 8] <= sh_q;
      end
    end
  end

  // armed is derived, so neither a host write nor clear can touch it
  always_ff @(posedge clock) begin
    if (!resetn) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= thr_q != 32'h0000_0000;
    end
  end

  assign cnt_open = !cfg_lock_q || permit_q;
  assign tick = tdiv_q == 32'(QTR_CYC - 1);
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ela_q <= 32'h0000_0000;
      tts_q <= 32'h0000_0000;
      evt_cnt_q <= 16'h0000;
      ovf_q <= 1'b0;
      tdiv_q <= 32'h0000_0000;
    end else if (do_clr) begin
      ela_q <= 32'h0000_0000;
      tts_q <= 32'h0000_0000;
      evt_cnt_q <= 16'h0000;
      ovf_q <= 1'b0;
      tdiv_q <= 32'h0000_0000;
    end else begin
      if (wr_en && in_ela && cnt_open) begin
        ela_q[{o_ela[1:0], 3'h0} +: 8] <= sh_q;
        tts_q[{o_ela[1:0], 3'h0} +: 8] <= sh_q;
      end
      if (wr_en && in_evt && cnt_open) begin
        evt_cnt_q[{o_evt[0], 3'h0} +: 8] <= sh_q;
      end
      if (evt_r) begin
        ela_q <= tts_q;
        tdiv_q <= 32'h0000_0000;
      end else if (evt && tick) begin
        tdiv_q <= 32'h0000_0000;
        if (ela_q != `ETCS_ELA_MAX) begin
          ela_q <= ela_q + 32'h0000_0001;
        end
      end else if (evt) begin
        tdiv_q <= tdiv_q + 32'h0000_0001;
      end
      if (evt_f) begin
        tts_q <= ela_q;
        if (evt_cnt_q != `ETCS_CNT_MAX) begin
          evt_cnt_q <= evt_cnt_q + 16'h0001;
        end else if (!ovf_q) begin
          ovf_q <= 1'b1;
          evt_cnt_q <= 16'h0000;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      act_q <= 1'b0;
      act_p_q <= 1'b0;
    end else begin
      act_q <= armed_q && (sense_q ? ela_q >= thr_q : ela_q < thr_q);
      act_p_q <= act_q;
    end
  end

  // set wins over clear when the alarm reasserts in the clearing cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      flag_q <= 1'b0;
    end else if (act_q && (!act_p_q || evt_f)) begin
      flag_q <= 1'b1;
    end else if (do_clr || !act_q) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      umem_q <= '0;
    end else if (do_clr && !mem_lock_q) begin
      umem_q <= '0;
    end else if (wr_en && in_um && !mem_lock_q) begin
      umem_q[o_um[3:0]] <= sh_q;
    end
  end

  etcs_alm_if al ();
  assign al.active = act_q;
  assign al.style = style_q;
  assign al.pin_low = ~apin;
  etcs_alarm_pulse #(
    .LOW_CYC(LOW_CYC),
    .HIGH_CYC(HIGH_CYC)
  ) u_pulse (
    .clock(clock),
    .resetn(resetn),
    .al(al.sink)
  );

  // open-drain pins only ever pull low
  always_ff @(posedge clock) begin
    if (!resetn) begin
      zero_q <= 1'b0;
    end else begin
      zero_q <= 1'b0;
    end
  end
  assign sda_out = zero_q;
  assign sda_oe = oe_q;
  assign alarm_out = zero_q;
  assign alarm_oe = al.drive;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence key_twice_s;
    wr_en && ptr_q == `ETCS_A_CFGL && sh_q == `ETCS_LOCK_KEY &&
    cfg_hit_q;
  endsequence
  armed_follow_a: assert property (
    thr_q != 32'h0000_0000 ##1 $stable(thr_q) |=> armed_q)
    else $error("armed not set by threshold");
  flag_track_a: assert property (
    act_q && !act_p_q |=> flag_q)
    else $error("flag missed alarm onset");
  cfg_lock_set_a: assert property (
    key_twice_s |=> cfg_lock_q ##1 cfg_lock_q)
    else $error("config lock not set");
  thr_frozen_a: assert property (
    cfg_lock_q |=> $stable(thr_q) && $stable(style_q))
    else $error("locked threshold changed");
  cnt_frozen_a: assert property (
    cfg_lock_q && !permit_q && wr_en |=> $stable(evt_cnt_q) &&
    $stable(tts_q))
    else $error("locked counter written");
  umem_frozen_a: assert property (
    mem_lock_q && wr_en |=> $stable(umem_q))
    else $error("locked user memory written");
  clear_gate_a: assert property (
    wr_en && !evt && ptr_q == `ETCS_A_CLR && !permit_q |=>
    $stable(thr_q) && $stable(ela_q))
    else $error("clear honoured without permit");
  clear_all_a: assert property (
    do_clr && !cfg_lock_q && !mem_lock_q |=> thr_q == 32'h0000_0000 &&
    ela_q == 32'h0000_0000 && evt_cnt_q == 16'h0000 && !(|umem_q))
    else $error("clear left state behind");
  wrap_once_a: assert property (
    evt_f && !ovf_q && evt_cnt_q == `ETCS_CNT_MAX |=> ovf_q &&
    evt_cnt_q == 16'h0000)
    else $error("counter did not wrap into overflow");
  stick_max_a: assert property (
    evt_f && ovf_q && evt_cnt_q == `ETCS_CNT_MAX |=>
    evt_cnt_q == `ETCS_CNT_MAX)
    else $error("counter wrapped twice");
  lock_reads_a: assert property (
    ld_q && ($past(ptr_q) == `ETCS_A_CFGL ||
    $past(ptr_q) == `ETCS_A_MEML) |-> sh_q == 8'h00)
    else $error("lock register read nonzero");
  ack_hold_a: assert property (
    state_q == ST_ACK |-> oe_q)
    else $error("acknowledge not held");
  nack_free_a: assert property (
    state_q == ST_TXACK |-> !oe_q)
    else $error("sda held after read byte");
  start_entry_a: assert property (
    start && !evt |=> state_q == ST_RX && bit_q == 4'h0)
    else $error("start not taken");
  event_mute_a: assert property (
    evt |=> !oe_q && state_q == ST_IDLE)
    else $error("bus answered during event");
endmodule : etcs_top
